// ---- hw/igs_consts.vh ----
// Constants of the group-0 interrupt source latch
`ifndef IGS_CONSTS_VH
`define IGS_CONSTS_VH

// Register word indices; the byte address on the AXI4-Lite bus is four times the index
`define IGS_ADDR_W 17
`define IGS_SRC_IDX 15'h7f00
`define IGS_MASK_IDX 15'h7f01
`define IGS_DMASEL_IDX 15'h7f74
`define IGS_SRC_ADDR 17'h1fc00
`define IGS_MASK_ADDR 17'h1fc04
`define IGS_DMASEL_ADDR 17'h1fdd0

// Reset values
`define IGS_SRC_RST 8'h00
`define IGS_MASK_RST 8'hff
`define IGS_DMASEL_RST 8'hff

// Source register bit positions
`define IGS_BIT_EXT3 7
`define IGS_BIT_EXT2 6
`define IGS_BIT_EXT1 5
`define IGS_BIT_EXT0 4
`define IGS_BIT_RXPKT 3
`define IGS_BIT_TXEMPTY 2
`define IGS_BIT_TXPKT 1
`define IGS_BIT_DMA 0

// Widths
`define IGS_TXQ_NUM 16
`define IGS_DMA_W 8

// AXI responses
`define IGS_RESP_OKAY 2'b00
`define IGS_RESP_SLVERR 2'b10

`endif

// ---- hw/igs_rise_det.v ----
// Per-bit low-to-high edge detector
`timescale 1ns/10ps
module igs_rise_det #(
  parameter W = 8
) (
  input wire aclk,            // Clock
  input wire aresetn,         // Synchronous reset, active low
  input wire [W-1:0] sig_in,  // Levels to watch
  output wire [W-1:0] rise    // High in the cycle a bit goes from 0 to 1
);

  reg [W-1:0] prev_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      // Track the input in reset so an idle-high level gives no false edge
      prev_ff <= sig_in;
    end else begin
      prev_ff <= sig_in;
    end
  end

  assign rise = sig_in & ~prev_ff;

endmodule // igs_rise_det

// ---- hw/igs_source_latch.v ----
// Group-0 interrupt source latch with AXI4-Lite register access
//
// Contract
// - 8-bit source register, reset zero, writing a one clears that bit; bits 7..4 show external inputs.
// - Bit 3 sets when a packet number is queued on the receive queue.
// - Bit 2 sets when any enabled transmit queue of sixteen becomes empty.
// - Bit 1 sets each time a packet is transmitted successfully.
// - Bit 0 sets when a selected DMA channel reaches terminal count or requests.
// - Every latched source bit clears as a side effect of reading the register.
// - Mask register resets all ones; zero enables, one masks the matching source.
// - After a clearing read, new DMA status rises on selected channels set bit 0 again.
`timescale 1ns/10ps
`include "igs_consts.vh"
module igs_source_latch (
  input wire aclk,                            // Clock, 10 MHz
  input wire aresetn,                         // Synchronous reset, active low
  // AXI4-Lite write address channel
  input wire [`IGS_ADDR_W-1:0] s_axi_awaddr,  // Write byte address
  input wire [2:0] s_axi_awprot,              // Protection, unused
  input wire s_axi_awvalid,                   // Write address valid
  output wire s_axi_awready,                  // Write address ready
  // AXI4-Lite write data channel
  input wire [31:0] s_axi_wdata,              // Write data
  input wire [3:0] s_axi_wstrb,               // Byte enables
  input wire s_axi_wvalid,                    // Write data valid
  output wire s_axi_wready,                   // Write data ready
  // AXI4-Lite write response channel
  output wire [1:0] s_axi_bresp,              // Write response
  output wire s_axi_bvalid,                   // Write response valid
  input wire s_axi_bready,                    // Write response ready
  // AXI4-Lite read address channel
  input wire [`IGS_ADDR_W-1:0] s_axi_araddr,  // Read byte address
  input wire [2:0] s_axi_arprot,              // Protection, unused
  input wire s_axi_arvalid,                   // Read address valid
  output wire s_axi_arready,                  // Read address ready
  // AXI4-Lite read data channel
  output wire [31:0] s_axi_rdata,             // Read data
  output wire [1:0] s_axi_rresp,              // Read response
  output wire s_axi_rvalid,                   // Read data valid
  input wire s_axi_rready,                    // Read data ready
  // Event sources
  input wire ext_int_in3,                     // External interrupt pin 3, async
  input wire ext_int_in2,                     // External interrupt pin 2, async
  input wire ext_int_in1,                     // External interrupt pin 1, async
  input wire ext_int_in0,                     // External interrupt pin 0, async
  input wire rx_packet_queued,                // Pulse: packet number queued
  input wire [15:0] tx_queue_empty,           // Level per transmit queue: empty
  input wire [15:0] tx_queue_enable,          // Level per transmit queue: enabled
  input wire tx_packet_sent,                  // Pulse: packet transmitted
  input wire [7:0] dma_channel_status,        // Terminal count and request bits
  // Interrupt output
  output wire mcu_ext_int_line_0              // Level, active high
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  reg awready_ff;
  reg wready_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg arready_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg irq_ff;

  reg aw_held_ff;
  reg w_held_ff;
  reg [`IGS_ADDR_W-1:0] waddr_ff;
  reg [7:0] wdata_ff;
  reg wlane0_ff;

  reg [7:0] src_ff;
  reg [7:0] mask_ff;
  reg [7:0] dmasel_ff;
  reg [3:0] ext_meta_ff;
  reg [3:0] ext_sync_ff;

  reg nxt_aw_held;
  reg nxt_w_held;
  reg nxt_bvalid;
  reg [1:0] nxt_bresp;
  reg nxt_rvalid;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  reg [7:0] nxt_src;
  reg [7:0] nxt_mask;
  reg [7:0] nxt_dmasel;
  reg [7:0] src_set;
  reg [7:0] src_clr;
  reg nxt_irq;

  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_write;
  wire wr_src;
  wire wr_mask;
  wire wr_dmasel;
  wire wr_hit;
  wire rd_src;
  wire rd_mask;
  wire rd_dmasel;
  wire [15:0] txq_rise;
  wire [7:0] dma_rise;

  // ---------------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign mcu_ext_int_line_0 = irq_ff;

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  assign aw_take = s_axi_awvalid & awready_ff;
  assign w_take = s_axi_wvalid & wready_ff;
  assign ar_take = s_axi_arvalid & arready_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

  // Word index compare; byte address bits 1:0 are ignored
  assign wr_src = do_write & (waddr_ff[`IGS_ADDR_W-1:2] == `IGS_SRC_IDX);
  assign wr_mask = do_write & (waddr_ff[`IGS_ADDR_W-1:2] == `IGS_MASK_IDX);
  assign wr_dmasel = do_write & (waddr_ff[`IGS_ADDR_W-1:2] == `IGS_DMASEL_IDX);
  assign wr_hit = wr_src | wr_mask | wr_dmasel;
  assign rd_src = s_axi_araddr[`IGS_ADDR_W-1:2] == `IGS_SRC_IDX;
  assign rd_mask = s_axi_araddr[`IGS_ADDR_W-1:2] == `IGS_MASK_IDX;
  assign rd_dmasel = s_axi_araddr[`IGS_ADDR_W-1:2] == `IGS_DMASEL_IDX;

  // ---------------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------------
  // An enabled queue that goes empty, or an empty queue that gets enabled
  igs_rise_det #(
    .W(`IGS_TXQ_NUM)
  ) u_txq_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(tx_queue_empty & tx_queue_enable),
    .rise(txq_rise)
  );

  // Only channels selected by the DMA select register are watched
  igs_rise_det #(
    .W(`IGS_DMA_W)
  ) u_dma_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(dma_channel_status & ~dmasel_ff),
    .rise(dma_rise)
  );

  always @* begin
    src_set = 8'h00;
    src_set[`IGS_BIT_EXT3] = ext_sync_ff[3];
    src_set[`IGS_BIT_EXT2] = ext_sync_ff[2];
    src_set[`IGS_BIT_EXT1] = ext_sync_ff[1];
    src_set[`IGS_BIT_EXT0] = ext_sync_ff[0];
    src_set[`IGS_BIT_RXPKT] = rx_packet_queued;
    src_set[`IGS_BIT_TXEMPTY] = |txq_rise;
    src_set[`IGS_BIT_TXPKT] = tx_packet_sent;
    src_set[`IGS_BIT_DMA] = |dma_rise;
  end

  // ---------------------------------------------------------------------
  // Register next state
  // ---------------------------------------------------------------------
  always @* begin
    src_clr = 8'h00;
    if (ar_take && rd_src) begin
      src_clr = 8'hff;
    end
    if (wr_src && wlane0_ff) begin
      src_clr = src_clr | wdata_ff;
    end
    // A new event in the clearing cycle stays set
    nxt_src = (src_ff & ~src_clr) | src_set;
    nxt_mask = mask_ff;
    if (wr_mask && wlane0_ff) begin
      nxt_mask = wdata_ff;
    end
    nxt_dmasel = dmasel_ff;
    if (wr_dmasel && wlane0_ff) begin
      nxt_dmasel = wdata_ff;
    end
  end

  // ---------------------------------------------------------------------
  // Bus channel next state
  // ---------------------------------------------------------------------
  always @* begin
    nxt_aw_held = (aw_held_ff & ~do_write) | aw_take;
    nxt_w_held = (w_held_ff & ~do_write) | w_take;
    nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
    nxt_bresp = bresp_ff;
    if (do_write) begin
      if (wr_hit) begin
        nxt_bresp = `IGS_RESP_OKAY;
      end else begin
        nxt_bresp = `IGS_RESP_SLVERR;
      end
    end
    nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_take) begin
      nxt_rresp = `IGS_RESP_OKAY;
      if (rd_src) begin
        nxt_rdata = {24'h000000, src_ff};
      end else if (rd_mask) begin
        nxt_rdata = {24'h000000, mask_ff};
      end else if (rd_dmasel) begin
        nxt_rdata = {24'h000000, dmasel_ff};
      end else begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `IGS_RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt line
  // ---------------------------------------------------------------------
  // Line follows latched, unmasked bits one cycle late
  always @* begin
    nxt_irq = |(src_ff & ~mask_ff);
  end

  // ---------------------------------------------------------------------
  // Bus flip-flops
  // ---------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `IGS_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `IGS_RESP_OKAY;
      irq_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waddr_ff <= {`IGS_ADDR_W{1'b0}};
      wdata_ff <= 8'h00;
      wlane0_ff <= 1'b0;
    end else begin
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff <= ~nxt_w_held & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      irq_ff <= nxt_irq;
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      if (aw_take) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata[7:0];
        wlane0_ff <= s_axi_wstrb[0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_ff <= `IGS_SRC_RST;
      mask_ff <= `IGS_MASK_RST;
      dmasel_ff <= `IGS_DMASEL_RST;
    end else begin
      src_ff <= nxt_src;
      mask_ff <= nxt_mask;
      dmasel_ff <= nxt_dmasel;
    end
  end

  // ---------------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------------
  // Two stages for the asynchronous pins; only the second stage is read
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_ff <= 4'h0;
      ext_sync_ff <= 4'h0;
    end else begin
      ext_meta_ff <= {ext_int_in3, ext_int_in2, ext_int_in1, ext_int_in0};
      ext_sync_ff <= ext_meta_ff;
    end
  end

endmodule // igs_source_latch

// ---- verif/igs_chk_checker.sv ----
// Assertion checker for the group-0 source latch
`timescale 1ns/10ps
`include "igs_consts.vh"
module igs_chk (
  input wire aclk, // Clock
  input wire aresetn, // Reset
  input wire [`IGS_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // AR valid
  input wire s_axi_arready, // AR ready
  input wire [31:0] s_axi_rdata, // Read data
  input wire [1:0] s_axi_rresp, // Read response
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire [1:0] s_axi_bresp, // Write response
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire rx_packet_queued, // Rx event
  input wire tx_packet_sent, // Tx event
  input wire mcu_ext_int_line_0 // Interrupt line
);
  wire ar_src = s_axi_arvalid && s_axi_arready && s_axi_araddr == `IGS_SRC_ADDR;
  wire [1:0] ev = {rx_packet_queued, tx_packet_sent};
  reg [1:0] exp_ff;
  reg [1:0] snap_ff;
  reg src_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Model of bits 3 and 1: a clearing read loses to a same-cycle event
  always @(posedge aclk) begin
    if (!aresetn) begin
      exp_ff <= 2'h0;
      snap_ff <= 2'h0;
      src_ff <= 1'b0;
    end else begin
      if (ar_src) snap_ff <= exp_ff;
      if (s_axi_arvalid && s_axi_arready) src_ff <= ar_src;
      exp_ff <= (ar_src ? 2'h0 : exp_ff) | ev;
    end
  end
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data repeated");
  property p_hi_zero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("second read taken");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_src_ok; $rose(s_axi_rvalid) && src_ff |-> s_axi_rresp == 2'b00; endproperty
  a_src_ok: assert property (p_src_ok) else $error("source read refused");
  property p_src_rx; $rose(s_axi_rvalid) && src_ff |-> s_axi_rdata[3] == snap_ff[1]; endproperty
  a_src_rx: assert property (p_src_rx) else $error("rx bit wrong");
  property p_src_tx; $rose(s_axi_rvalid) && src_ff |-> s_axi_rdata[1] == snap_ff[0]; endproperty
  a_src_tx: assert property (p_src_tx) else $error("tx bit wrong");
  c_src: cover property (ar_src && ev[0]);
  c_irq: cover property (mcu_ext_int_line_0);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // igs_chk

bind igs_source_latch igs_chk i_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .rx_packet_queued, .tx_packet_sent, .mcu_ext_int_line_0);

// ---- verif/igs_evt_src.sv ----
// Event producer standing in for the buffer manager and DMA logic
`timescale 1ns/10ps
module igs_evt_src (
  input wire aclk, // Clock
  input wire [2:0] code, // Event to raise next cycle
  output reg rx_packet_queued, // Packet number queued
  output reg tx_packet_sent, // Packet sent
  output reg [15:0] tx_queue_empty, // Queue empty levels
  output reg [7:0] dma_channel_status // Channel status levels
);
  always @(posedge aclk) begin
    rx_packet_queued <= code == 3'h1;
    tx_packet_sent <= code == 3'h2;
    // Queue 15 idles empty; code 3 queues one packet that drains a cycle later
    tx_queue_empty <= {code != 3'h3, 14'h0, code == 3'h6};
    dma_channel_status <= {6'h0, code == 3'h5, code == 3'h4};
  end
endmodule // igs_evt_src

// ---- verif/igs_source_latch_tb.sv ----
// Self-checking bench for the group-0 source latch
`timescale 1ns/10ps
`include "igs_consts.vh"
module igs_source_latch_tb;
  // Rows: expected source, external pins, event code
  localparam [175:0] ROWS = {16'h0801, 16'h0202, 16'h0403, 16'h0006, 16'h0104,
    16'h0104, 16'h0005, 16'h8080, 16'h4040, 16'h2020, 16'h1010};
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [`IGS_ADDR_W-1:0] s_axi_awaddr = {`IGS_ADDR_W{1'b0}}, s_axi_araddr = {`IGS_ADDR_W{1'b0}};
  reg [15:0] tx_queue_enable = 16'h8000;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [3:0] ext = 4'h0;
  reg [2:0] code = 3'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire mcu_ext_int_line_0, rx_packet_queued, tx_packet_sent;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] tx_queue_empty;
  wire [7:0] dma_channel_status;
  integer fail_count = 0, checked = 0, cyc = 0, i;
  reg [31:0] rd_d;
  reg [1:0] rd_r;
  igs_evt_src i_src (.aclk, .code, .rx_packet_queued, .tx_packet_sent, .tx_queue_empty,
    .dma_channel_status);
  igs_source_latch i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_int_in3(ext[3]), .ext_int_in2(ext[2]), .ext_int_in1(ext[1]), .ext_int_in0(ext[0]),
    .rx_packet_queued, .tx_queue_empty, .tx_queue_enable, .tx_packet_sent,
    .dma_channel_status, .mcu_ext_int_line_0);
  always #50 aclk = ~aclk;
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] expd);
    begin
      checked = checked + 1;
      if (seen !== expd) begin
        fail_count = fail_count + 1;
        $display("BAD %0s expected %h seen %h", nm, expd, seen);
      end
    end
  endtask
  task wr(input [`IGS_ADDR_W-1:0] a, input [7:0] d, input [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_bvalid) begin
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        @(posedge aclk);
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  task rd(input [`IGS_ADDR_W-1:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_rvalid) begin
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        @(posedge aclk);
      end
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task fire(input [2:0] c);
    begin
      code <= c;
      @(posedge aclk);
      code <= 3'h0;
      repeat (3) @(posedge aclk);
    end
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`IGS_SRC_ADDR);
    chk("src_rst", rd_d, 32'h0);
    rd(`IGS_MASK_ADDR);
    chk("mask_rst", rd_d, 32'hff);
    wr(`IGS_DMASEL_ADDR, 8'hfe, 2'b00);
    // Each row is serviced in full before the next one starts
    for (i = 0; i < 11; i = i + 1) begin
      ext <= ROWS[i*16+4 +: 4];
      fire(ROWS[i*16 +: 3]);
      repeat (2) @(posedge aclk);
      rd(`IGS_SRC_ADDR);
      chk("src_row", rd_d, {24'h0, ROWS[i*16+8 +: 8]});
      ext <= 4'h0;
      repeat (4) @(posedge aclk);
      rd(`IGS_SRC_ADDR);
      chk("src_clr", rd_d, {24'h0, ROWS[i*16+4 +: 4], 4'h0});
    end
    wr(`IGS_MASK_ADDR, 8'hfd, 2'b00);
    fire(3'h2);
    chk("irq_on", {31'h0, mcu_ext_int_line_0}, 32'h1);
    rd(`IGS_SRC_ADDR);
    chk("irq_src", rd_d, 32'h2);
    repeat (2) @(posedge aclk);
    chk("irq_off", {31'h0, mcu_ext_int_line_0}, 32'h0);
    wr(`IGS_MASK_ADDR, 8'hff, 2'b00);
    fire(3'h2);
    chk("irq_mask", {31'h0, mcu_ext_int_line_0}, 32'h0);
    rd(`IGS_SRC_ADDR);
    // Event in the same cycle as the clearing read survives it
    code <= 3'h2;
    @(posedge aclk);
    code <= 3'h0;
    rd(`IGS_SRC_ADDR);
    chk("win_rd1", rd_d, 32'h0);
    rd(`IGS_SRC_ADDR);
    chk("win_rd2", rd_d, 32'h2);
    // Word index 7f03 is not decoded
    rd(17'h1fc0c);
    chk("bad_resp", {30'h0, rd_r}, 32'h2);
    chk("bad_data", rd_d, 32'h0);
    wr(17'h1fc0c, 8'h5a, 2'b10);
    // Writing a one clears only that bit; the other stays latched
    fire(3'h4);
    fire(3'h2);
    wr(`IGS_SRC_ADDR, 8'h01, 2'b00);
    rd(`IGS_SRC_ADDR);
    chk("w1c_src", rd_d, 32'h2);
    fire(3'h1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`IGS_SRC_ADDR);
    chk("src_rst2", rd_d, 32'h0);
    complete_run;
  end
endmodule // igs_source_latch_tb
